// ### verilog/tbm_pkg.sv
// Shared constants for the telecom bus / line output pin multiplexer
package tbm_pkg;

   // ****************************************************************
   // Register port
   // ****************************************************************
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;
   localparam logic [15:0] CTL_CH0_ADDR = 16'h1f01;
   localparam logic [15:0] CTL_CH4_ADDR = 16'h5f01;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;

   // ****************************************************************
   // Field positions, crossing depth and read latency
   // ****************************************************************
   localparam int unsigned EDGE_INV_BIT = 2;
   localparam int unsigned SYNC_STAGES = 2;
   localparam int unsigned READ_LATENCY = 1;

endpackage : tbm_pkg

// ### verilog/tbm_line_launch.sv
// Line-clock launcher: rising or falling edge output stage with crossings
`timescale 1ns/1ps

module tbm_line_launch #(
   parameter int unsigned SYNC_STAGES = tbm_pkg::SYNC_STAGES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic invert_i,
   input wire logic sts1_i,
   input wire logic data_i,
   output logic data_o,
   output logic fall_active_o
);

   // ****************************************************************
   // Crossing from the register clock
   // ****************************************************************
   // Bits: 0 reset, 1 clock enable, 2 edge invert, 3 STS-1 mode
   logic [3:0] sync_q [SYNC_STAGES];
   logic [3:0] sync_d [SYNC_STAGES];
   logic rst_s;
   logic ce_s;
   logic inv_s;
   logic sts1_s;

   // One stage alone would let a metastable level reach the launch flops
   if (SYNC_STAGES < 2) begin : g_bad_stages
      $error("tbm_line_launch needs at least two sync stages");
   end

   // One stage per entry; stage 0 feeds only stage 1
   for (genvar g = 0; g < SYNC_STAGES; g++) begin : g_sync
      if (g == 0) begin : g_first
         always_comb begin
            sync_d[g] = {sts1_i, invert_i, ce_i, rst_i};
         end
      end else begin : g_next
         always_comb begin
            sync_d[g] = sync_q[g-1];
         end
      end
      always_ff @(posedge clk_i) begin
         sync_q[g] <= sync_d[g];
      end
   end

   assign rst_s = sync_q[SYNC_STAGES-1][0];
   assign ce_s = sync_q[SYNC_STAGES-1][1];
   assign inv_s = sync_q[SYNC_STAGES-1][2];
   assign sts1_s = sync_q[SYNC_STAGES-1][3];

   // ****************************************************************
   // Launch flops
   // ****************************************************************
   logic rise_q;
   logic rise_d;
   logic fall_q;
   logic fall_d;
   logic use_fall_q;
   logic use_fall_d;

   // STS-1 traffic always launches on the rising edge
   always_comb begin
      rise_d = rise_q;
      use_fall_d = use_fall_q;
      if (rst_s) begin
         rise_d = 1'b0;
         use_fall_d = 1'b0;
      end else if (ce_s) begin
         rise_d = data_i;
         use_fall_d = inv_s & ~sts1_s;
      end
   end

   always_ff @(posedge clk_i) begin
      rise_q <= rise_d;
      use_fall_q <= use_fall_d;
   end

   // Half-cycle retime: falling flop re-launches the rising value
   always_comb begin
      fall_d = fall_q;
      if (rst_s) begin
         fall_d = 1'b0;
      end else if (ce_s) begin
         fall_d = rise_q;
      end
   end

   always_ff @(negedge clk_i) begin
      fall_q <= fall_d;
   end

   // Select is a flop on the rising edge so the mux never changes mid-bit
   assign data_o = use_fall_q ? fall_q : rise_q;
   assign fall_active_o = use_fall_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_sts1_rising: assert property (@(posedge clk_i)
      disable iff (rst_s)
      (ce_s && sts1_s) |=> !use_fall_q)
      else $error("Falling-edge launch while in STS-1 mode");
   a_default_rise: assert property (@(posedge clk_i)
      disable iff (rst_s)
      !use_fall_q |-> data_o == rise_q)
      else $error("Rising-edge path not on output");
   a_invert_falls: assert property (@(posedge clk_i)
      disable iff (rst_s)
      (ce_s && inv_s && !sts1_s) |=> use_fall_q)
      else $error("Edge invert did not select falling edge");
   a_fall_retime: assert property (@(negedge clk_i)
      disable iff (rst_s)
      ce_s |=> fall_q == $past(rise_q))
      else $error("Falling launch did not follow rising value");
   a_fall_block4: assert property (@(posedge clk_i)
      disable iff (rst_s)
      ($rose(sts1_s) && ce_s) ##1 (sts1_s && ce_s) [*2] |=> !use_fall_q)
      else $error("STS-1 mode still launching on falling edge");

   c_fall_used: cover property (@(posedge clk_i) disable iff (rst_s)
      use_fall_q ##1 use_fall_q);
   c_sts1_block: cover property (@(posedge clk_i) disable iff (rst_s)
      inv_s && sts1_s ##1 !use_fall_q);

endmodule : tbm_line_launch

// ### verilog/tbm_line_output_mux.sv
// Shared drop bus bit 3 / channel 4 line data pin, with line edge control
//
// Operation
// - Channel 0 DS3/E3 data leaves on falling line clock when invert bit set
// - Channel 0 STS-1 data never leaves on the falling line clock edge
// - Pin function follows the channel 0 telecom bus enable
// - Bus enabled: pin carries drop bus bit 3, launched on drop clock rise
// - Bus disabled: pin carries channel 4 single-rail line data
// - By default channel 4 line data leaves on the rising line clock edge
// - Channel 4 DS3/E3 data leaves on falling line clock when invert bit set
// - Channel 4 STS-1 data never leaves on the falling line clock edge
`timescale 1ns/1ps

module tbm_line_output_mux (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Register port
   input wire logic [tbm_pkg::ADDR_W-1:0] addr_i,
   input wire logic [tbm_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [tbm_pkg::DATA_W-1:0] rdata_o,
   // Mode inputs from the rest of the device
   input wire logic telecom_bus_enable_i,
   input wire logic sts1_mode_ch0_i,
   input wire logic sts1_mode_ch4_i,
   // Drop bus domain
   input wire logic drop_bus_clock_ch0_i,
   input wire logic drop_bus_bit3_ch0_i,
   // Line clock domains
   input wire logic line_clk_ch0_i,
   input wire logic line_data_ch0_i,
   input wire logic line_clk_ch4_i,
   input wire logic line_data_ch4_i,
   // Pins
   output logic line_clock_out_ch0_o,
   output logic line_data_out_ch0_o,
   output logic line_clock_out_ch4_o,
   output logic rx_side_bus_bit3_o
);

   // ****************************************************************
   // I/O control registers
   // ****************************************************************
   logic [7:0] ctl0_q;
   logic [7:0] ctl0_d;
   logic [7:0] ctl4_q;
   logic [7:0] ctl4_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic hit0;
   logic hit4;

   // Full 16-bit decode, so no alias can flip a launch edge by accident
   assign hit0 = (addr_i == tbm_pkg::CTL_CH0_ADDR);
   assign hit4 = (addr_i == tbm_pkg::CTL_CH4_ADDR);

   // Writes land one edge later; unmapped reads return zero
   // Read and write in one cycle: the read returns the old value
   always_comb begin
      ctl0_d = ctl0_q;
      ctl4_d = ctl4_q;
      rdata_d = rdata_q;
      if (rst_i) begin
         ctl0_d = tbm_pkg::CTL_RESET;
         ctl4_d = tbm_pkg::CTL_RESET;
         rdata_d = tbm_pkg::UNMAPPED_DATA;
      end else if (ce_i) begin
         if (wr_i && hit0) begin
            ctl0_d = wdata_i;
         end
         if (wr_i && hit4) begin
            ctl4_d = wdata_i;
         end
         if (rd_i) begin
            if (hit0) begin
               rdata_d = ctl0_q;
            end else if (hit4) begin
               rdata_d = ctl4_q;
            end else begin
               rdata_d = tbm_pkg::UNMAPPED_DATA;
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      ctl0_q <= ctl0_d;
      ctl4_q <= ctl4_d;
      rdata_q <= rdata_d;
   end

   assign rdata_o = rdata_q;

   // Only the edge invert bit acts; other bits are plain storage
   logic inv_ch0;
   logic inv_ch4;
   assign inv_ch0 = ctl0_q[tbm_pkg::EDGE_INV_BIT];
   assign inv_ch4 = ctl4_q[tbm_pkg::EDGE_INV_BIT];

   // ****************************************************************
   // Launch stages, one per launch clock (channel 0, channel 4, drop bus)
   // ****************************************************************
   // Each stage takes reset, enable and its control bits across into
   // its own clock through two flops before any logic reads them
   logic ch0_data;
   logic ch4_data;
   logic drop_data;
   logic ch0_fall;
   logic ch4_fall;

   // Channel 0 line data with selectable launch edge
   tbm_line_launch u_ch0 (
      .clk_i(line_clk_ch0_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .invert_i(inv_ch0),
      .sts1_i(sts1_mode_ch0_i),
      .data_i(line_data_ch0_i),
      .data_o(ch0_data),
      .fall_active_o(ch0_fall)
   );

   // Channel 4 line data with selectable launch edge
   tbm_line_launch u_ch4 (
      .clk_i(line_clk_ch4_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .invert_i(inv_ch4),
      .sts1_i(sts1_mode_ch4_i),
      .data_i(line_data_ch4_i),
      .data_o(ch4_data),
      .fall_active_o(ch4_fall)
   );

   // Drop bus bit: invert tied low, so it always launches on the rise
   tbm_line_launch u_drop (
      .clk_i(drop_bus_clock_ch0_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .invert_i(1'b0),
      .sts1_i(1'b0),
      .data_i(drop_bus_bit3_ch0_i),
      .data_o(drop_data),
      .fall_active_o()
   );

   // ****************************************************************
   // Pin assignment
   // ****************************************************************
   // Clocks are forwarded straight so data and clock keep their phase
   assign line_clock_out_ch0_o = line_clk_ch0_i;
   assign line_clock_out_ch4_o = line_clk_ch4_i;
   // Channel 0 data keeps a pin of its own; only channel 4 shares
   assign line_data_out_ch0_o = ch0_data;

   // Static select: changing the enable mid-frame glitches the pin
   assign rx_side_bus_bit3_o = telecom_bus_enable_i ? drop_data
                                                    : ch4_data;

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_reset_clears: assert property (@(posedge ref_clk_i)
      rst_i |=> (ctl0_q == 8'h00 && ctl4_q == 8'h00))
      else $error("Control registers not cleared by reset");
   // Register side: writes, reads and the clock-enable freeze
   a_write_ch0: assert property (@(posedge ref_clk_i)
      disable iff (rst_i)
      (ce_i && wr_i && hit0) |=> ctl0_q == $past(wdata_i))
      else $error("Channel 0 control write lost");
   a_write_ch4: assert property (@(posedge ref_clk_i)
      disable iff (rst_i)
      (ce_i && wr_i && hit4) |=> ctl4_q == $past(wdata_i))
      else $error("Channel 4 control write lost");
   a_read_back: assert property (@(posedge ref_clk_i)
      disable iff (rst_i)
      (ce_i && rd_i && hit4 && !wr_i) |=> rdata_o == $past(ctl4_q))
      else $error("Channel 4 control read mismatch");
   a_read_ch0: assert property (@(posedge ref_clk_i)
      disable iff (rst_i)
      (ce_i && rd_i && hit0) |=> rdata_o == $past(ctl0_q))
      else $error("Channel 0 control read mismatch");
   a_stray_write: assert property (@(posedge ref_clk_i)
      disable iff (rst_i)
      (wr_i && !hit0 && !hit4) |=>
         (ctl0_q == $past(ctl0_q) && ctl4_q == $past(ctl4_q)))
      else $error("Unmapped write changed a control register");
   a_freeze_regs: assert property (@(posedge ref_clk_i)
      disable iff (rst_i)
      !ce_i |=>
         (ctl0_q == $past(ctl0_q) && ctl4_q == $past(ctl4_q)))
      else $error("Control register changed while enable low");

   // Pin function follows the bus enable
   a_pin_drop: assert property (@(posedge ref_clk_i)
      disable iff (rst_i)
      telecom_bus_enable_i |-> rx_side_bus_bit3_o == drop_data)
      else $error("Pin not carrying drop bus bit");
   a_pin_line: assert property (@(posedge ref_clk_i)
      disable iff (rst_i)
      !telecom_bus_enable_i |-> rx_side_bus_bit3_o == ch4_data)
      else $error("Pin not carrying channel 4 line data");

   // Mode and enable must hold four line edges: two sync stages and the
   // select flop have to catch up before the edge choice settles
   a_ch0_sts1: assert property (@(posedge line_clk_ch0_i)
      disable iff (rst_i)
      (sts1_mode_ch0_i && ce_i) [*4] |-> !ch0_fall)
      else $error("Channel 0 falling launch in STS-1 mode");
   a_ch4_sts1: assert property (@(posedge line_clk_ch4_i)
      disable iff (rst_i)
      (sts1_mode_ch4_i && ce_i) [*4] |-> !ch4_fall)
      else $error("Channel 4 falling launch in STS-1 mode");

   // Main scenarios: pin hand-over, invert write, falling launch
   c_pin_switch: cover property (@(posedge ref_clk_i) disable iff (rst_i)
      telecom_bus_enable_i ##1 !telecom_bus_enable_i);
   c_ch4_invert: cover property (@(posedge ref_clk_i) disable iff (rst_i)
      ce_i && wr_i && hit4 && wdata_i[tbm_pkg::EDGE_INV_BIT]);
   c_ch0_fall: cover property (@(posedge line_clk_ch0_i)
      disable iff (rst_i) ch0_fall);

endmodule : tbm_line_output_mux

// ### verif/tbm_liu_model.sv
// Behavioural line interface receiver watching one line data pin
`timescale 1ns/1ps

module tbm_liu_model (
   input wire logic clk_i,
   input wire logic data_i,
   output logic rise_chg_o,
   output logic fall_chg_o
);
   logic after_rise = 1'b0;
   logic after_fall = 1'b0;

   // Sample just after each edge; a change flag shows which edge launched
   always @(posedge clk_i) begin
      #2;
      after_rise = data_i;
      rise_chg_o = (after_rise !== after_fall);
   end

   // Same on the falling edge, so both launch edges are told apart
   always @(negedge clk_i) begin
      #2;
      after_fall = data_i;
      fall_chg_o = (after_fall !== after_rise);
   end
endmodule : tbm_liu_model

// ### verif/testbench.sv
// Self-checking bench for the shared drop bus / line data pin
`timescale 1ns/1ps

module testbench;
   logic clk, rst, ce, lclk, dclk, wr, rd, en, s0, s4, d0, d4, dbit;
   logic tog, v;
   logic [15:0] addr;
   logic [7:0] wdata, rdata;
   logic lco0, ldo0, lco4, pin, r0, f0, r4, f4;
   int fails = 0;
   int comparisons = 0;

   tbm_line_output_mux u_dut (.ref_clk_i(clk), .rst_i(rst), .ce_i(ce),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .telecom_bus_enable_i(en), .sts1_mode_ch0_i(s0),
      .sts1_mode_ch4_i(s4), .drop_bus_clock_ch0_i(dclk),
      .drop_bus_bit3_ch0_i(dbit), .line_clk_ch0_i(lclk),
      .line_data_ch0_i(d0), .line_clk_ch4_i(lclk), .line_data_ch4_i(d4),
      .line_clock_out_ch0_o(lco0), .line_data_out_ch0_o(ldo0),
      .line_clock_out_ch4_o(lco4), .rx_side_bus_bit3_o(pin));
   tbm_liu_model u_liu0 (.clk_i(lco0), .data_i(ldo0), .rise_chg_o(r0),
      .fall_chg_o(f0));
   tbm_liu_model u_liu4 (.clk_i(lco4), .data_i(pin), .rise_chg_o(r4),
      .fall_chg_o(f4));

   // ***********************************************************
   // Clocks and stimulus helpers
   // ***********************************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Line and drop clocks start off phase from the register clock
   initial begin
      lclk = 1'b0;
      #7;
      forever #16 lclk = ~lclk;
   end
   initial begin
      dclk = 1'b0;
      #3;
      forever #20 dclk = ~dclk;
   end
   // Line data toggles every cycle so every launch edge is visible
   always @(negedge lclk) if (tog) begin
      d0 <= ~d0;
      d4 <= ~d4;
   end
   always @(negedge dclk) dbit <= ~dbit;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask : wr_reg

   // Read data is registered one cycle after the strobe edge
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      chk(rdata, exp);
   endtask : rd_chk

   // Expect falling-edge launch on a channel whose invert acts
   task automatic launch(input bit inv0, input bit inv4);
      repeat (8) @(posedge lclk);
      repeat (4) begin
         @(posedge lclk);
         #8;
         chk({6'h00, r0, f0}, inv0 ? 8'h01 : 8'h02);
         chk({6'h00, r4, f4}, inv4 ? 8'h01 : 8'h02);
      end
   endtask : launch

   task automatic end_of_test;
      $display("counts: comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test

   // Watchdog: a hang counts as a mismatch
   initial begin
      #200000;
      fails++;
      end_of_test();
   end

   // ***********************************************************
   // Main sequence
   // ***********************************************************
   initial begin
      {rst, ce, wr, rd, en, s0, s4, d0, d4, dbit, tog} = 11'h600;
      addr = 16'h0000;
      wdata = 8'h00;
      repeat (11) @(negedge clk);
      rst = 1'b0;
      wr_reg(16'h0000, 8'hff);
      rd_chk(tbm_pkg::CTL_CH0_ADDR, tbm_pkg::CTL_RESET);
      rd_chk(tbm_pkg::CTL_CH4_ADDR, tbm_pkg::CTL_RESET);
      $display("test registers after reset done");
      tog = 1'b1;
      launch(1'b0, 1'b0);
      $display("test default rising launch done");
      wr_reg(tbm_pkg::CTL_CH0_ADDR, 8'h04);
      rd_chk(tbm_pkg::CTL_CH0_ADDR, 8'h04);
      launch(1'b1, 1'b0);
      $display("test channel 0 falling launch done");
      wr_reg(tbm_pkg::CTL_CH4_ADDR, 8'h04);
      rd_chk(tbm_pkg::CTL_CH4_ADDR, 8'h04);
      rd_chk(16'h0000, tbm_pkg::UNMAPPED_DATA);
      ce = 1'b0;
      wr_reg(tbm_pkg::CTL_CH4_ADDR, 8'h00);
      ce = 1'b1;
      rd_chk(tbm_pkg::CTL_CH4_ADDR, 8'h04);
      launch(1'b1, 1'b1);
      $display("test falling launch and enable freeze done");
      @(negedge clk);
      s0 = 1'b1;
      s4 = 1'b1;
      launch(1'b0, 1'b0);
      $display("test sts1 blocks falling launch done");
      @(negedge clk);
      en = 1'b1;
      repeat (6) begin
         @(posedge dclk);
         v = dbit;
         #2;
         chk({7'h00, pin}, {7'h00, v});
      end
      $display("test drop bus bit on pin done");
      end_of_test();
   end
endmodule : testbench
